// ==== ssc_pkg.sv ====
`default_nettype none
package ssc_pkg;
  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_TX_HOLDING = 8'h00;
  localparam logic [7:0] ADR_RX_HOLDING = 8'h04;
  localparam logic [7:0] ADR_BAUD_DIV = 8'h08;
  localparam logic [7:0] ADR_SERIAL_MODE = 8'h0C;
  localparam logic [7:0] ADR_CTRL_A = 8'h10;
  localparam logic [7:0] ADR_CTRL_B = 8'h14;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int SCLK_ORIGIN_BIT = 3;
  localparam int SRC_LSB = 0;
  localparam int SRC_MSB = 1;
  localparam int SHIFTER_VACANT_BIT = 3;
  localparam int OPENDRAIN_BIT = 5;
  localparam int EDGE_SEL_BIT = 6;
  localparam int BIT_ORDER_BIT = 7;
  localparam int TX_ALLOW_BIT = 0;
  localparam int TX_VACANT_BIT = 1;
  localparam int RX_ALLOW_BIT = 2;
  localparam int RX_DONE_BIT = 3;
  localparam int IRQ_POINT_BIT = 4;
  localparam int RX_CHAIN_BIT = 5;
  localparam int OVERRUN_BIT = 12;

  // ------------------------------------------------------------
  // values
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_SYNC = 3'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] OVERRUN_BIT_IDX = 3'h6;
  localparam logic [1:0] SRC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_DIV8 = 2'h1;
  localparam logic [2:0] PRE8_LAST = 3'h7;
  localparam logic [4:0] PRE32_LAST = 5'h1F;

  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} state_t;
endpackage : ssc_pkg
`default_nettype wire

// ==== ssc_rate_gen.sv ====
`default_nettype none
module ssc_rate_gen
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // control
  input wire logic i_run,
  input wire logic [1:0] i_src_sel,
  input wire logic [7:0] i_div,
  // half period tick
  output logic o_tick
);
  logic [4:0] pre_cnt;
  logic [7:0] div_cnt;
  logic pre_tick;

  // ------------------------------------------------------------
  // prescaler: f1, f8 or f32
  // ------------------------------------------------------------
  always_comb begin
    case (i_src_sel)
      SRC_DIV1: pre_tick = 1'b1;
      SRC_DIV8: pre_tick = (pre_cnt[2:0] == PRE8_LAST);
      default: pre_tick = (pre_cnt == PRE32_LAST);
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt <= 5'h00;
    end else if (!i_run) begin
      pre_cnt <= 5'h00;
    end else begin
      pre_cnt <= pre_cnt + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // n+1 divider, tick every half period
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= 8'h00;
    end else if (!i_run) begin
      div_cnt <= 8'h00;
    end else if (pre_tick) begin
      div_cnt <= (div_cnt == i_div) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  assign o_tick = i_run && pre_tick && (div_cnt == i_div);
endmodule : ssc_rate_gen
`default_nettype wire

// ==== ssc_channel.sv ====
// Added by the designer: the address map and the Wishbone interface to the registers.
`default_nettype none
module ssc_channel
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // serial link
  input wire logic I_SCLK_PIN,
  output logic O_SCLK_PIN,
  output logic O_SCLK_PIN_OE,
  output logic O_SERIAL_OUT_PIN,
  output logic O_SERIAL_OUT_PIN_OE,
  input wire logic I_SERIAL_IN_PIN,
  // interrupt requests
  output logic O_TX_IRQ,
  output logic O_RX_IRQ
);
  // ------------------------------------------------------------
  // registers and state
  // ------------------------------------------------------------
  logic [7:0] tx_holding_reg;
  logic [7:0] rx_data;
  logic [7:0] baud_divider_reg;
  logic [7:0] serial_mode_reg;
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic tx_holding_vacant;
  logic rx_done_flag;
  logic rx_overrun_flag;
  logic chain_go;
  state_t state;
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic [2:0] bit_cnt;
  logic rx_active;
  logic sclk_int;
  logic txd_bit;
  logic sclk_s1, sclk_s2, sclk_s3;
  logic sin_s1, sin_s2;
  logic wb_req, wb_wr, wb_rd, tick;
  logic mode_on, sclk_origin_sel, tx_allow, rx_allow, tx_irq_point_sel, rx_chain_mode;
  logic txd_opendrain_sel, sclk_edge_sel, bit_order_sel, idle_lvl;
  logic start, drive_evt, samp_evt, done;
  logic [31:0] next_rdata;

  function automatic logic [7:0] shift8(input logic [7:0] v, input logic din, input logic msb);
    shift8 = msb ? {v[6:0], din} : {din, v[7:1]};
  endfunction : shift8

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  assign mode_on = (serial_mode_reg[MODE_MSB:MODE_LSB] == MODE_SYNC);
  assign sclk_origin_sel = serial_mode_reg[SCLK_ORIGIN_BIT];
  assign txd_opendrain_sel = ctrl_a[OPENDRAIN_BIT];
  assign sclk_edge_sel = ctrl_a[EDGE_SEL_BIT];
  assign bit_order_sel = ctrl_a[BIT_ORDER_BIT];
  assign tx_allow = ctrl_b[TX_ALLOW_BIT];
  assign rx_allow = ctrl_b[RX_ALLOW_BIT];
  assign tx_irq_point_sel = ctrl_b[IRQ_POINT_BIT];
  assign rx_chain_mode = ctrl_b[RX_CHAIN_BIT];
  assign idle_lvl = !sclk_edge_sel;

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wb_wr = wb_req && I_WB_WE && I_WB_SEL[0];
  assign wb_rd = wb_req && !I_WB_WE;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_WB_ACK <= 1'b0;
    end else begin
      O_WB_ACK <= wb_req;
    end
  end

  always_comb begin
    next_rdata = WORD_ZERO;
    case (I_WB_ADR)
      ADR_RX_HOLDING: begin
        next_rdata[7:0] = rx_data;
        next_rdata[OVERRUN_BIT] = rx_overrun_flag;
      end
      ADR_BAUD_DIV: next_rdata[7:0] = baud_divider_reg;
      ADR_SERIAL_MODE: next_rdata[7:0] = serial_mode_reg;
      ADR_CTRL_A: begin
        next_rdata[7:0] = ctrl_a;
        next_rdata[SHIFTER_VACANT_BIT] = (state == ST_IDLE);
      end
      ADR_CTRL_B: begin
        next_rdata[7:0] = ctrl_b;
        next_rdata[TX_VACANT_BIT] = tx_holding_vacant;
        next_rdata[RX_DONE_BIT] = rx_done_flag;
      end
      default: next_rdata = WORD_ZERO;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_WB_DAT <= WORD_ZERO;
    end else if (wb_rd) begin
      O_WB_DAT <= next_rdata;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      baud_divider_reg <= BYTE_ZERO;
      serial_mode_reg <= BYTE_ZERO;
      ctrl_a <= BYTE_ZERO;
      ctrl_b <= BYTE_ZERO;
    end else if (wb_wr) begin
      case (I_WB_ADR)
        ADR_BAUD_DIV: baud_divider_reg <= I_WB_DAT[7:0];
        ADR_SERIAL_MODE: serial_mode_reg <= I_WB_DAT[7:0];
        ADR_CTRL_A: ctrl_a <= I_WB_DAT[7:0] & ~(8'h01 << SHIFTER_VACANT_BIT);
        ADR_CTRL_B: ctrl_b <= I_WB_DAT[7:0] & ~((8'h01 << TX_VACANT_BIT) | (8'h01 << RX_DONE_BIT));
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // transmit holding buffer
  // ------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_holding_reg <= BYTE_ZERO;
    end else if (wb_wr && I_WB_ADR == ADR_TX_HOLDING) begin
      tx_holding_reg <= I_WB_DAT[7:0];
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_holding_vacant <= 1'b1;
    end else if (wb_wr && I_WB_ADR == ADR_TX_HOLDING) begin
      tx_holding_vacant <= 1'b0;
    end else if (start) begin
      tx_holding_vacant <= 1'b1;
    end
  end

  // chain mode: a read of received data arms the next reception
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      chain_go <= 1'b0;
    end else if (wb_rd && I_WB_ADR == ADR_RX_HOLDING && rx_chain_mode) begin
      chain_go <= 1'b1;
    end else if (start || !rx_chain_mode) begin
      chain_go <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      sin_s1 <= 1'b1;
      sin_s2 <= 1'b1;
    end else begin
      sclk_s1 <= I_SCLK_PIN;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sin_s1 <= I_SERIAL_IN_PIN;
      sin_s2 <= sin_s1;
    end
  end

  // ------------------------------------------------------------
  // shift clock: internal divider or pin
  // ------------------------------------------------------------
  ssc_rate_gen u_rate (
    .i_core_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_run(state == ST_SHIFT && !sclk_origin_sel),
    .i_src_sel(ctrl_a[SRC_MSB:SRC_LSB]),
    .i_div(baud_divider_reg),
    .o_tick(tick)
  );

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sclk_int <= 1'b1;
    end else if (state == ST_SHIFT && tick) begin
      sclk_int <= !sclk_int;
    end else if (state == ST_IDLE) begin
      sclk_int <= idle_lvl;
    end
  end

  always_comb begin
    if (sclk_origin_sel) begin
      drive_evt = (sclk_s3 == idle_lvl) && (sclk_s2 != idle_lvl);
      samp_evt = (sclk_s3 != idle_lvl) && (sclk_s2 == idle_lvl);
    end else begin
      drive_evt = tick && (sclk_int == idle_lvl);
      samp_evt = tick && (sclk_int != idle_lvl);
    end
    drive_evt = drive_evt && state == ST_SHIFT;
    samp_evt = samp_evt && state == ST_SHIFT;
  end

  assign start = state == ST_IDLE && mode_on && tx_allow && (!tx_holding_vacant || chain_go);
  assign done = samp_evt && bit_cnt == LAST_BIT;

  assign O_SCLK_PIN = sclk_int;
  assign O_SCLK_PIN_OE = mode_on && !sclk_origin_sel;

  // ------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (start) state <= ST_SHIFT;
        ST_SHIFT: if (done || !mode_on) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_active <= 1'b0;
    end else if (start) begin
      rx_active <= rx_allow;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      bit_cnt <= 3'h0;
    end else if (start) begin
      bit_cnt <= 3'h0;
    end else if (samp_evt) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // holding contents go out even when only receiving
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_shift <= BYTE_ZERO;
      txd_bit <= 1'b1;
    end else if (start) begin
      tx_shift <= tx_holding_reg;
      txd_bit <= 1'b1;
    end else if (drive_evt) begin
      txd_bit <= bit_order_sel ? tx_shift[7] : tx_shift[0];
      tx_shift <= shift8(tx_shift, 1'b0, bit_order_sel);
    end else if (state == ST_IDLE) begin
      txd_bit <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_shift <= BYTE_ZERO;
    end else if (samp_evt) begin
      rx_shift <= shift8(rx_shift, sin_s2, bit_order_sel);
    end
  end

  assign O_SERIAL_OUT_PIN = txd_bit;
  assign O_SERIAL_OUT_PIN_OE = !(txd_opendrain_sel && txd_bit);

  // ------------------------------------------------------------
  // receive holding and flags
  // ------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_data <= BYTE_ZERO;
    end else if (done && rx_active) begin
      rx_data <= shift8(rx_shift, sin_s2, bit_order_sel);
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_done_flag <= 1'b0;
    end else if (done && rx_active) begin
      rx_done_flag <= 1'b1;
    end else if (wb_rd && I_WB_ADR == ADR_RX_HOLDING) begin
      rx_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_overrun_flag <= 1'b0;
    end else if (samp_evt && rx_active && bit_cnt == OVERRUN_BIT_IDX && rx_done_flag) begin
      rx_overrun_flag <= 1'b1;
    end else if (!rx_allow || !mode_on) begin
      rx_overrun_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt request pulses
  // ------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TX_IRQ <= 1'b0;
      O_RX_IRQ <= 1'b0;
    end else begin
      O_TX_IRQ <= tx_irq_point_sel ? done : start;
      O_RX_IRQ <= done && rx_active && !rx_overrun_flag;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence s_load;
    start ##0 !tx_irq_point_sel;
  endsequence

  sequence s_finish;
    done ##0 tx_irq_point_sel;
  endsequence

  chk_start_needs_data: assert property ($rose(state == ST_SHIFT) |-> $past(tx_allow && mode_on && (!tx_holding_vacant || chain_go)))
    else $error("transfer started without data or allow");
  chk_rx_needs_tx: assert property ((state == ST_SHIFT && rx_active) |-> $past(tx_allow))
    else $error("reception without transmit allow");
  chk_irq_on_load: assert property (s_load |=> O_TX_IRQ ##1 !O_TX_IRQ)
    else $error("tx request missing at load");
  chk_irq_on_finish: assert property (s_finish |=> O_TX_IRQ && state == ST_IDLE)
    else $error("tx request missing at finish");
  chk_rx_done_set: assert property ((done && rx_active) |=> rx_done_flag)
    else $error("rx done flag not set");
  chk_overrun_set: assert property ((samp_evt && rx_active && bit_cnt == OVERRUN_BIT_IDX && rx_done_flag) |=> rx_overrun_flag)
    else $error("overrun not flagged");
  chk_idle_line: assert property ((state == ST_IDLE && !start) |=> O_SERIAL_OUT_PIN)
    else $error("data line not high in idle");
  chk_byte_len: assert property (done |-> bit_cnt == LAST_BIT && state == ST_SHIFT)
    else $error("frame not eight bits");
  chk_od_release: assert property ((txd_opendrain_sel && O_SERIAL_OUT_PIN) |-> !O_SERIAL_OUT_PIN_OE)
    else $error("open drain line driven high");
  chk_holding_taken: assert property (start |=> state == ST_SHIFT &&
    (tx_holding_vacant || $past(wb_wr && I_WB_ADR == ADR_TX_HOLDING)))
    else $error("holding not emptied at load");
endmodule : ssc_channel
`default_nettype wire

// ==== ssc_partner.sv ====
`default_nettype none
module ssc_partner (
  // link
  input wire logic i_sclk,
  input wire logic i_data_in,
  output logic o_data_out,
  output logic o_sclk,
  // setup
  input wire logic i_edge_sel,
  input wire logic i_msb_first,
  input wire logic i_clear,
  input wire logic i_go,
  input wire logic [7:0] i_tx_byte,
  output logic [7:0] o_rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] n_drv;
  logic [3:0] n_smp;
  logic [7:0] shreg;

  // ----------------------------------------------------------
  // external shift clock, idle level set by edge select
  // ----------------------------------------------------------
  always @(i_edge_sel or posedge i_go) begin
    o_sclk = ~i_edge_sel;
    if (i_go) begin
      repeat (16) begin
        #250;
        o_sclk = ~o_sclk;
      end
    end
  end

  // ----------------------------------------------------------
  // drive on one edge, sample on the other
  // ----------------------------------------------------------
  always @(i_sclk or posedge i_clear) begin
    if (i_clear) begin
      n_drv = 4'h0;
      n_smp = 4'h0;
    end else if (i_sclk === i_edge_sel) begin
      o_data_out = i_tx_byte[i_msb_first ? 3'h7 - n_drv[2:0] : n_drv[2:0]];
      n_drv = n_drv + 4'h1;
    end else begin
      shreg = i_msb_first ? {shreg[6:0], i_data_in} : {i_data_in, shreg[7:1]};
      n_smp = n_smp + 4'h1;
      if (n_smp == 4'h8) begin
        o_rx_byte = shreg;
        n_smp = 4'h0;
        n_drv = 4'h0;
        o_data_out <= #100 ~o_data_out;
      end
    end
  end

  initial begin
    o_data_out = 1'b0;
    o_rx_byte = 8'h00;
    shreg = 8'h00;
  end
endmodule : ssc_partner
`default_nettype wire

// ==== sync_serial_channel_tb.sv ====
`default_nettype none
module sync_serial_channel_tb import ssc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cyc, stb, we, ack, ack_q, sclk, sclk_oe, sout, sout_oe, tx_irq, rx_irq;
  logic p_sclk, p_data, p_edge, p_msb, p_clear, p_go, sclk_w, sout_w, sclk_q;
  logic [7:0] adr, p_tx, p_rx;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int num_errors, checks_done, cyc_n, half, last_chg, tx_at, rx_at, n_tx, n_rx;

  assign sclk_w = sclk_oe ? sclk : p_sclk;
  assign sout_w = sout_oe ? sout : 1'b1;

  ssc_channel u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_SCLK_PIN(sclk_w), .O_SCLK_PIN(sclk), .O_SCLK_PIN_OE(sclk_oe), .O_SERIAL_OUT_PIN(sout),
    .O_SERIAL_OUT_PIN_OE(sout_oe), .I_SERIAL_IN_PIN(p_data), .O_TX_IRQ(tx_irq), .O_RX_IRQ(rx_irq));

  ssc_partner u_partner (.i_sclk(sclk_w), .i_data_in(sout_w), .o_data_out(p_data), .o_sclk(p_sclk),
    .i_edge_sel(p_edge), .i_msb_first(p_msb), .i_clear(p_clear), .i_go(p_go), .i_tx_byte(p_tx),
    .o_rx_byte(p_rx));

  // ----------------------------------------------------------
  // clock and event monitor
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk) begin
    cyc_n++;
    sclk_q <= sclk;
    if (sclk !== sclk_q) begin
      half = cyc_n - last_chg;
      last_chg = cyc_n;
    end
    if (tx_irq === 1'b1) begin
      tx_at = cyc_n;
      n_tx++;
    end
    if (rx_irq === 1'b1) begin
      rx_at = cyc_n;
      n_rx++;
    end
  end

  // ----------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {WORD_ZERO[31:8], wd};
    do begin
      @(negedge clk);
    end while (ack !== 1'b1);
    @(posedge clk);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    wb(1'b0, a, BYTE_ZERO, x);
    chk(x & m, e);
  endtask : rdc

  task automatic wait_cnt(ref int c, input int tgt);
    int k;
    k = 0;
    while (c < tgt && k < 20000) begin
      @(posedge clk);
      k++;
    end
  endtask : wait_cnt

  task automatic frame(input logic [7:0] ca, dv, cb, tb, pb, input int hp, input logic ext, wtx);
    int t0, r0;
    t0 = n_tx;
    r0 = n_rx;
    if (wtx) begin
      wr(ADR_CTRL_A, ca);
      wr(ADR_BAUD_DIV, dv);
      wr(ADR_CTRL_B, cb);
    end
    p_edge <= ca[EDGE_SEL_BIT];
    p_msb <= ca[BIT_ORDER_BIT];
    p_tx <= pb;
    p_clear <= 1'b1;
    @(posedge clk);
    p_clear <= 1'b0;
    if (wtx) wr(ADR_TX_HOLDING, tb);
    if (ext) begin
      @(posedge clk);
      p_go <= 1'b1;
      @(posedge clk);
      p_go <= 1'b0;
    end
    wait_cnt(n_rx, r0 + 1);
    chk(n_rx - r0, 1);
    if (wtx) chk(n_tx - t0, 1);
    rdc(ADR_CTRL_B, 32'h0000_0008, 32'h0000_0008);
    rdc(ADR_CTRL_A, 32'h0000_0008, 32'h0000_0008);
    rdc(ADR_RX_HOLDING, 32'h0000_10FF, {WORD_ZERO[31:8], pb});
    if (wtx) chk({WORD_ZERO[31:8], p_rx}, {WORD_ZERO[31:8], tb});
    if (hp > 0) chk(half, hp);
    if (wtx && hp > 0) chk(32'(tx_at + 8 * hp < rx_at), 32'(!cb[IRQ_POINT_BIT]));
  endtask : frame

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  logic [7:0] t_ca [7] = '{8'h00, 8'h80, 8'h40, 8'h01, 8'h02, 8'h00, 8'h00};
  logic [7:0] t_dv [7] = '{8'h03, 8'h03, 8'h03, 8'h00, 8'h00, 8'hFF, 8'h03};
  int t_hp [7] = '{4, 4, 4, 8, 32, 256, 4};

  initial begin
    {rst, cyc, stb, we, p_edge, p_msb, p_clear, p_go} = 8'h80;
    adr = 8'h00;
    sel = 4'h1;
    wdat = WORD_ZERO;
    p_tx = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wr(ADR_SERIAL_MODE, {5'h00, MODE_SYNC});
    @(posedge clk);
    chk({WORD_ZERO[31:3], sclk_oe, sout, sout_oe}, 32'h0000_0007);
    rdc(ADR_CTRL_B, 32'h0000_0002, 32'h0000_0002);
    rdc(ADR_CTRL_A, 32'h0000_0008, 32'h0000_0008);
    rdc(8'h18, 32'hFFFF_FFFF, WORD_ZERO);
    wr(ADR_CTRL_A, 8'h20);
    @(posedge clk);
    chk({WORD_ZERO[31:1], sout_oe}, WORD_ZERO);
    $display("test idle done");
    for (int i = 0; i < 7; i++) begin
      frame(t_ca[i], t_dv[i], (i == 6) ? 8'h15 : 8'h05, 8'hA5 + 8'(i * 17), 8'h3C ^ 8'(i * 9),
        t_hp[i], 1'b0, 1'b1);
    end
    $display("test internal frames done");
    begin
      int r0, t0;
      r0 = n_rx;
      t0 = n_tx;
      wr(ADR_TX_HOLDING, 8'h11);
      wr(ADR_TX_HOLDING, 8'h22);
      rdc(ADR_CTRL_B, 32'h0000_0002, 32'h0000_0000);
      wait_cnt(n_tx, t0 + 1);
      wait_cnt(n_tx, t0 + 2);
      chk(n_tx - t0, 2);
      chk(n_rx - r0, 1);
      chk({WORD_ZERO[31:8], p_rx}, 32'h0000_0022);
      rdc(ADR_RX_HOLDING, 32'h0000_1000, 32'h0000_1000);
    end
    $display("test overrun done");
    wr(ADR_CTRL_B, BYTE_ZERO);
    wr(ADR_SERIAL_MODE, 8'h09);
    @(posedge clk);
    chk({WORD_ZERO[31:1], sclk_oe}, WORD_ZERO);
    frame(8'h00, 8'h03, 8'h25, 8'hC3, 8'h5A, 0, 1'b1, 1'b1);
    frame(8'h00, 8'h03, 8'h25, 8'hC3, 8'h96, 0, 1'b1, 1'b0);
    $display("test external chain done");
    wrap_up();
  end

  initial begin
    #1ms;
    num_errors++;
    wrap_up();
  end
endmodule : sync_serial_channel_tb
`default_nettype wire
